// [logic/ssc_cfg.svh]
/*
 * Constants for the serial port timing configuration block: register
 * offsets, field positions, reset values and timing figures.
 * Assumes it is included by bare name; definitions only.
 */
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define SSC_STATUS_OFF 12'h094
`define SSC_CTRL_OFF 12'h098
`define SSC_STATUS_RST 8'h00
`define SSC_CTRL_RST 8'h00

// ****************************************************************
// Status register fields
// ****************************************************************
`define SSC_PHASE_BIT 7
`define SSC_CKE_BIT 6
`define SSC_RO_MSB 5

// ****************************************************************
// Control register fields (mode, master, idle polarity)
// ****************************************************************
`define SSC_MODE_BIT 0
`define SSC_MST_BIT 1
`define SSC_POL_BIT 2

// ****************************************************************
// Timing: half a serial bit period, in ns, and its cycle count
// ****************************************************************
`define SSC_CLK_PERIOD_NS 4
`define SSC_HALF_BIT_NS 40
`define SSC_HALF_BIT_CYC \
   ((`SSC_HALF_BIT_NS + `SSC_CLK_PERIOD_NS - 1) / `SSC_CLK_PERIOD_NS)

`endif

// [logic/ssc_pkg.sv]
/*
 * Types shared by the serial port timing configuration block.
 * Assumes the constants header is present alongside.
 */
package ssc_pkg;

   typedef enum logic [0:0] {
      SSC_MODE_SPI = 1'b0,
      SSC_MODE_I2C = 1'b1
   } ssc_mode_t;

   typedef enum logic [1:0] {
      SSC_AX_IDLE = 2'b00,
      SSC_AX_WRESP = 2'b01,
      SSC_AX_RDATA = 2'b10
   } ssc_axst_t;

endpackage : ssc_pkg

// [logic/ssc_regs.sv]
/*
 * Small register store for the serial port configuration: two 8-bit
 * words with write enable, read data from a register.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`include "ssc_cfg.svh"

module ssc_regs (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic wr_sel,
   input wire logic [7:0] wr_data,
   input wire logic rd_sel,
   output logic [7:0] rd_data,
   output logic [7:0] word0,
   output logic [7:0] word1
);

   // Word 0 keeps only its two writable bits; the rest read as zero.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         word0 <= `SSC_STATUS_RST;
         word1 <= `SSC_CTRL_RST;
      end else if (wr_en) begin
         if (wr_sel) begin
            word1 <= {5'h00, wr_data[2:0]};
         end else begin
            word0 <= {wr_data[7:6], 6'h00};
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= rd_sel ? word1 : word0;
      end
   end

endmodule : ssc_regs

// [logic/ssc_top.sv]
/*
 * Serial port timing configuration: status/configuration register over
 * AXI4-Lite, sample-point and transmit-edge selection for SPI, and the
 * slew-rate control output for I2C.
 * Assumes one 250 MHz clock and a serial clock input from a pin.
 */
// The AXI4-Lite interface to the registers is this design's own decision.
// Operation
// (R1) The port works in exactly one mode at a time, SPI or I2C.
// (R2) Status at 94h: bits 7:6 read-write, bits 5:0 read-only, reset zero.
// (R3) SPI master with the sample bit clear samples mid output time.
// (R4) SPI master with the sample bit set samples at end of output time.
// (R5) Software keeps the sample bit clear for SPI slave operation.
// (R6) In I2C mode the sample bit set turns slew control off, clear on.
// (R7) The edge bit picks the SPI transmit edge; idle polarity reverses it.
`timescale 1ns/1ps
`include "ssc_cfg.svh"

module ssc_top #(
   parameter int unsigned HALF_BIT_CYC = `SSC_HALF_BIT_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_clk_in,
   input wire logic serial_data_in,
   output logic tx_edge_strobe,
   output logic rx_sample_strobe,
   output logic rx_data_bit,
   output logic slew_ctrl_en,
   output logic i2c_mode
);

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   logic aw_hold_r;
   logic w_hold_r;
   logic [11:0] awaddr_r;
   logic [7:0] wdata_r;
   logic wstrb0_r;
   logic wr_go;
   logic wr_hit;
   logic rd_hit_r;
   logic rd_sel_r;
   logic [7:0] rd_data;
   logic [7:0] stat_w;
   logic [7:0] ctrl_w;
   ssc_pkg::ssc_axst_t st_r;

   assign wr_go = aw_hold_r && w_hold_r && st_r == ssc_pkg::SSC_AX_IDLE;
   assign wr_hit = awaddr_r == `SSC_STATUS_OFF
                   || awaddr_r == `SSC_CTRL_OFF;

   // Address and data are taken in either order and held until both.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 12'h000;
         wdata_r <= 8'h00;
         wstrb0_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_hold_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
         end else if (wr_go) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
         end else if (st_r == ssc_pkg::SSC_AX_WRESP && s_axi_bready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
         end else if (st_r == ssc_pkg::SSC_AX_WRESP && s_axi_bready) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Write response and read channel share one small sequencer.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ssc_pkg::SSC_AX_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'b00;
         s_axi_rdata <= 32'h00000000;
         rd_hit_r <= 1'b0;
         rd_sel_r <= 1'b0;
      end else begin
         s_axi_arready <= 1'b0;
         case (st_r)
            ssc_pkg::SSC_AX_IDLE: begin
               if (wr_go) begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
                  st_r <= ssc_pkg::SSC_AX_WRESP;
               end else if (s_axi_arvalid && !s_axi_arready) begin
                  s_axi_arready <= 1'b1;
                  rd_hit_r <= s_axi_araddr == `SSC_STATUS_OFF
                              || s_axi_araddr == `SSC_CTRL_OFF;
                  rd_sel_r <= s_axi_araddr == `SSC_CTRL_OFF;
                  st_r <= ssc_pkg::SSC_AX_RDATA;
               end
            end
            ssc_pkg::SSC_AX_WRESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  st_r <= ssc_pkg::SSC_AX_IDLE;
               end
            end
            ssc_pkg::SSC_AX_RDATA: begin
               if (!s_axi_rvalid && !s_axi_arready) begin
                  s_axi_rvalid <= 1'b1;
                  s_axi_rresp <= rd_hit_r ? 2'b00 : 2'b10;
                  s_axi_rdata <= rd_hit_r ? {24'h000000, rd_data}
                                          : 32'h00000000;
               end else if (s_axi_rvalid && s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  st_r <= ssc_pkg::SSC_AX_IDLE;
               end
            end
            default: begin
               st_r <= ssc_pkg::SSC_AX_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // Register store
   // ****************************************************************
   ssc_regs u_regs (
      .clock(clock),
      .rst_n(rst_n),
      .wr_en(wr_go && wr_hit && wstrb0_r), // (R2)
      .wr_sel(awaddr_r == `SSC_CTRL_OFF),
      .wr_data(wdata_r),
      .rd_sel(rd_sel_r),
      .rd_data(rd_data),
      .word0(stat_w),
      .word1(ctrl_w)
   );

   // ****************************************************************
   // Mode and serial timing
   // ****************************************************************
   logic phase;
   logic cke;
   logic pol;
   logic master;
   ssc_pkg::ssc_mode_t mode;

   assign phase = stat_w[`SSC_PHASE_BIT];
   assign cke = stat_w[`SSC_CKE_BIT];
   assign pol = ctrl_w[`SSC_POL_BIT];
   assign master = ctrl_w[`SSC_MST_BIT];
   // One mode bit, so the two modes can never both be active.
   assign mode = ssc_pkg::ssc_mode_t'(ctrl_w[`SSC_MODE_BIT]); // (R1)

   // The serial clock comes from a pin and is synchronised first.
   logic sck_m_r;
   logic sck_s_r;
   logic sck_d_r;
   logic sd_m_r;
   logic sd_s_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sck_m_r <= 1'b0;
         sck_s_r <= 1'b0;
         sck_d_r <= 1'b0;
         sd_m_r <= 1'b0;
         sd_s_r <= 1'b0;
      end else begin
         sck_m_r <= serial_clk_in;
         sck_s_r <= sck_m_r;
         sck_d_r <= sck_s_r;
         sd_m_r <= serial_data_in;
         sd_s_r <= sd_m_r;
      end
   end

   logic rise;
   logic fall;
   logic tx_edge;
   assign rise = sck_s_r && !sck_d_r;
   assign fall = !sck_s_r && sck_d_r;
   // Edge select and idle polarity together pick the launch edge.
   assign tx_edge = (cke ^ pol) ? rise : fall; // (R7)

   // Half-bit counter from the launch edge places the sample point.
   logic [15:0] cnt_r;
   logic armed_r;
   logic sample_now;
   assign sample_now = armed_r
                       && cnt_r == 16'(HALF_BIT_CYC - 1); // (R3)

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 16'h0000;
         armed_r <= 1'b0;
      end else if (tx_edge) begin
         cnt_r <= 16'h0000;
         armed_r <= 1'b1;
      end else if (sample_now) begin
         armed_r <= 1'b0;
      end else if (armed_r) begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   logic spi_m;
   logic phase_eff;
   logic do_sample;
   assign spi_m = mode == ssc_pkg::SSC_MODE_SPI && master;
   // A slave ignores the sample bit; software keeps it clear there.
   assign phase_eff = spi_m && phase; // (R5)
   // Sampling at the end of output time uses the next launch edge.
   assign do_sample = mode == ssc_pkg::SSC_MODE_SPI
                      && (phase_eff ? tx_edge : sample_now); // (R4)

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_edge_strobe <= 1'b0;
         rx_sample_strobe <= 1'b0;
         rx_data_bit <= 1'b0;
         slew_ctrl_en <= 1'b0;
         i2c_mode <= 1'b0;
      end else begin
         tx_edge_strobe <= mode == ssc_pkg::SSC_MODE_SPI && tx_edge;
         rx_sample_strobe <= do_sample;
         if (do_sample) begin
            rx_data_bit <= sd_s_r;
         end
         slew_ctrl_en <= mode == ssc_pkg::SSC_MODE_I2C && !phase; // (R6)
         i2c_mode <= mode == ssc_pkg::SSC_MODE_I2C;
      end
   end

endmodule : ssc_top

// [verif/ssc_chk_assertions.sv]
/* Checker for the serial timing configuration block.
   Sees only the top module's ports; bound at the file's foot. */
`timescale 1ns/1ps
module ssc_chk #(
   parameter int unsigned HALF_BIT_CYC = 10
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tx_edge_strobe,
   input wire logic rx_sample_strobe,
   input wire logic slew_ctrl_en,
   input wire logic i2c_mode
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   wr_resp_a: assert property (wr_take |-> ##2 s_axi_bvalid)
      else $error("write response late");
   wr_drop_a: assert property (
      wr_take |=> !s_axi_awready && !s_axi_wready)
      else $error("write ready not dropped");
   b_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   r_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   // The read data register needs one cycle after the address is taken.
   ar_pulse_a: assert property (
      s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid)
      else $error("read answer wrong");
   r_width_a: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   slew_mode_a: assert property (slew_ctrl_en |-> i2c_mode)
      else $error("slew control outside i2c");
   sample_pt_a: assert property (
      rx_sample_strobe |-> tx_edge_strobe ||
      $past(tx_edge_strobe, HALF_BIT_CYC))
      else $error("sample point misplaced");
   tx_pulse_a: assert property (tx_edge_strobe |=> !tx_edge_strobe)
      else $error("transmit strobe too long");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (rx_sample_strobe && tx_edge_strobe);
   cover property (slew_ctrl_en);
endmodule : ssc_chk
bind ssc_top ssc_chk #(.HALF_BIT_CYC(HALF_BIT_CYC)) chk (.clock(clock),
   .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .tx_edge_strobe(tx_edge_strobe),
   .rx_sample_strobe(rx_sample_strobe), .slew_ctrl_en(slew_ctrl_en),
   .i2c_mode(i2c_mode));

// [verif/ssc_peer.sv]
/* Far-side serial peer: drives the serial clock and data pins.
   Assumes the bench calls its tasks; the clock stands still between. */
`timescale 1ns/1ps
module ssc_peer (
   input wire logic clock,
   output logic sclk,
   output logic sdat
);
   initial begin
      sclk = 1'b0;
      sdat = 1'b1;
   end
   // Idle: data shows the inverse of its last value, never a stale bit.
   task automatic park(input logic idle);
      @(posedge clock);
      sclk <= idle;
      sdat <= ~sdat;
   endtask : park
   task automatic flip(input logic d);
      @(posedge clock);
      sclk <= ~sclk;
      sdat <= d;
   endtask : flip
endmodule : ssc_peer

// [verif/testbench.sv]
/* Self-checking bench: AXI4-Lite register accesses and serial edges.
   Assumes the design files and the peer model are compiled first. */
`timescale 1ns/1ps
`include "ssc_cfg.svh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
   mismatches++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module testbench;
   localparam int HB = 3;
   logic clock = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd;
   logic awr, wr, bv, arr, rv, txs, rxs, rxb, slew, i2c, sclk, sdat;
   logic [1:0] bresp, rresp, r, bq;
   logic [3:0] ws = 4'h1;
   logic [7:0] d;
   int mismatches = 0, tests_run = 0;
   ssc_peer peer (.clock(clock), .sclk(sclk), .sdat(sdat));
   ssc_top #(.HALF_BIT_CYC(HB)) uut (.clock(clock), .rst_n(rst_n),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .serial_clk_in(sclk),
      .serial_data_in(sdat), .tx_edge_strobe(txs),
      .rx_sample_strobe(rxs), .rx_data_bit(rxb), .slew_ctrl_en(slew),
      .i2c_mode(i2c));
   initial forever #2 clock = ~clock;
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
      @(posedge clock);
      awa <= a; wd <= {24'h0, v}; awv <= 1; wv <= 1; br <= 1;
      forever begin
         @(posedge clock);
         if (awv && awr) awv <= 0;
         if (wv && wr) wv <= 0;
         if (bv) break;
      end
      bq = bresp;
      br <= 0;
   endtask : wr_reg
   task automatic rd_reg(input logic [11:0] a);
      @(posedge clock);
      ara <= a; arv <= 1; rr <= 1;
      forever begin
         @(posedge clock);
         if (arv && arr) arv <= 0;
         if (rv) break;
      end
      d = rd[7:0];
      r = rresp;
      rr <= 0;
   endtask : rd_reg
   // Leading or trailing pin edge; strobe checked, then sample lag and bit only when a launch strobe is seen.
   task automatic edge_chk(input logic ex, input logic ph, input logic b);
      int n;
      logic seen;
      seen = 0;
      n = 0;
      peer.flip(b);
      while (!seen && n < 8) begin
         @(posedge clock); #1;
         seen = txs;
         n++;
      end
      `CHK("tx_edge", ex, seen)
      if (seen) begin
         n = 0;
         while (rxs !== 1'b1 && n < 12) begin
            @(posedge clock); #1;
            n++;
         end
         `CHK("sample_lag", ph ? 0 : HB, n)
         @(posedge clock); #1;
         `CHK("rx_bit", b, rxb)
      end
      repeat (12) @(posedge clock);
   endtask : edge_chk
   task close_out;
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out
   initial begin
      #40000;
      mismatches++;
      close_out;
   end
   initial begin
      logic pol, cke, ph, mst;
      repeat (20) @(posedge clock);
      rst_n <= 1;
      rd_reg(`SSC_STATUS_OFF);
      `CHK("status_rst", 10'h000, {r, d})
      wr_reg(`SSC_STATUS_OFF, 8'hff);
      `CHK("wr_okay", 2'b00, bq)
      wr_reg(12'h0a0, 8'hff);
      `CHK("wr_unmapped", 2'b10, bq)
      // A write with byte lane 0 disabled must leave the register alone.
      ws <= 4'h0;
      wr_reg(`SSC_STATUS_OFF, 8'h00);
      ws <= 4'h1;
      rd_reg(`SSC_STATUS_OFF);
      `CHK("status_rw", 10'h0c0, {r, d})
      rd_reg(12'h0a0);
      `CHK("unmapped", 10'h200, {r, d})
      wr_reg(`SSC_CTRL_OFF, 8'h01);
      rd_reg(`SSC_CTRL_OFF);
      `CHK("ctrl_rb", 10'h001, {r, d})
      wr_reg(`SSC_STATUS_OFF, 8'h00);
      repeat (2) @(posedge clock); #1;
      `CHK("i2c_slew", 2'b11, {i2c, slew})
      wr_reg(`SSC_STATUS_OFF, 8'h80);
      repeat (2) @(posedge clock); #1;
      `CHK("no_slew", 2'b10, {i2c, slew})
      // Four master cases, then one slave case with the sample bit clear.
      for (int i = 0; i < 5; i++) begin
         pol = i[1];
         cke = i[0];
         mst = i < 4;
         ph = mst ? pol ^ cke : 1'b0;
         wr_reg(`SSC_CTRL_OFF, {5'h0, pol, mst, 1'b0});
         wr_reg(`SSC_STATUS_OFF, {ph, cke, 6'h0});
         peer.park(pol);
         repeat (12) @(posedge clock); #1;
         `CHK("spi_mode", 1'b0, i2c)
         edge_chk(cke, ph, cke);
         edge_chk(!cke, ph, cke);
      end
      close_out;
   end
endmodule : testbench
